/* fci_consts.svh */
// constants for the flash command host controller
`ifndef FCI_CONSTS_SVH
`define FCI_CONSTS_SVH
`define FCI_UNLOCK1_ADDR 20'h05555
`define FCI_UNLOCK2_ADDR 20'h02aaa
`define FCI_UNLOCK1_DATA 16'h00aa
`define FCI_UNLOCK2_DATA 16'h0055
`define FCI_CODE_RESET 16'h00f0
`define FCI_CODE_ID 16'h0090
`define FCI_CODE_PROGRAM 16'h00a0
`define FCI_CODE_ERASE_SETUP 16'h0080
`define FCI_CODE_CHIP_ERASE 16'h0010
`define FCI_CODE_SECTOR_ERASE 16'h0030
`define FCI_CODE_STATUS 16'h0070
`define FCI_CODE_CLEAR_STATUS 16'h0050
`define FCI_CODE_SUSPEND 16'h00b0
`define FCI_ID_MAKER_ADDR 20'h00000
`define FCI_ID_PART_ADDR 20'h00001
`define FCI_SECTOR_LSB 16
// strobe phase lengths in ns at a 5 ns clock
`define FCI_CLK_NS 5
`define FCI_SETUP_NS 20
`define FCI_PULSE_NS 60
`define FCI_HOLD_NS 20
`define FCI_READ_NS 200
`define FCI_PHASE_W 6
`define FCI_CYC(ns) ((ns + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`endif

/* fci_pkg.sv */
// types for the flash command host controller
package fci_pkg;
	typedef enum logic [3:0]
	{
		FCI_OP_READ = 4'h0,
		FCI_OP_RESET = 4'h1,
		FCI_OP_STATUS = 4'h2,
		FCI_OP_ID = 4'h3,
		FCI_OP_CLEAR = 4'h4,
		FCI_OP_PROGRAM = 4'h5,
		FCI_OP_CHIP_ERASE = 4'h6,
		FCI_OP_SECTOR_ERASE = 4'h7,
		FCI_OP_SUSPEND = 4'h8
	} fci_op_type;
	typedef enum logic [5:0]
	{
		FCI_IDLE = 6'b000001,
		FCI_SETUP = 6'b000010,
		FCI_PULSE = 6'b000100,
		FCI_HOLD = 6'b001000,
		FCI_NEXT = 6'b010000,
		FCI_DONE = 6'b100000
	} fci_state_type;
endpackage

/* fci_host.sv */
// host controller driving the flash pins with unlock command sequences
`timescale 1ns/100ps
`include "fci_consts.svh"

// Overview of operation
// [R01] writes drive chip select low, output gate high, write strobe low
// [R02] array reads drive chip select and output gate low, write strobe high
// [R03] bank half select is driven from the request and held each cycle
// [R04] read commands only change the device read path
// [R05] program and erase sequences start the device write engine
// [R06] while programming only status reads are issued meaningfully
// [R07] during erase only status reads and erase suspend are sensible
// [R08] after completion the device stays in status read mode
// [R09] every command opens with aa to 5555 and 55 to 2aaa
// [R10] device compares only address bits 0 to 14
// [R11] identifier read code 90 and clear status code 50
// [R12] read after reset code returns array data
// [R13] read after status code 70 returns status
// [R14] program a0 plus one write; chip erase 80, unlock, 10
// [R15] sector erase final write 30 at sector address bits 16 to 19
// [R16] device latches program address on strobe falling edge
// [R17] device latches program data on strobe rising edge
// [R18] high voltage on bit 9 exposes identifier bytes by address bit 0
// [R19] after identifier command reads at 00 and 01 give codes
// [R20] identifier mode ends only with the reset sequence; the device model also leaves it on status code 70 and after program or erase
// [R21] device powers up in array read mode
// [R22] array read mode persists until a valid command
// [R23] device floats data unless chip select and output gate are low; the device model drives the inverse of its last output instead
// [R24] operation done when status data bit 7 reads one; the host sets o_engine_ready only when bits 7 and 15 both read one
// [R25] mismatched writes abandon a partial sequence in the device
// [R26] write spans later falling edge to earlier rising edge
module fci_host
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// request side
	input wire logic i_req,
	input fci_pkg::fci_op_type i_op,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_bank_half_select,
	input wire logic i_id_high_voltage,
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_rdata,
	output logic o_engine_ready,
	// flash pins
	output logic [19:0] o_addr,
	output logic o_bank_half_select,
	output logic o_chip_select_n,
	output logic o_output_gate_n,
	output logic o_write_strobe_n,
	output logic o_identification_high_voltage,
	output logic [15:0] o_data,
	output logic o_data_oe,
	input wire logic [15:0] i_data
);
	import fci_pkg::*;

	localparam int SETUP_CYC = `FCI_CYC(`FCI_SETUP_NS);
	localparam int PULSE_CYC = `FCI_CYC(`FCI_PULSE_NS);
	localparam int HOLD_CYC = `FCI_CYC(`FCI_HOLD_NS);
	localparam int READ_CYC = `FCI_CYC(`FCI_READ_NS);

	fci_state_type state;
	fci_op_type op;
	logic [2:0] step;
	logic [2:0] last_step;
	logic [`FCI_PHASE_W-1:0] count;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic bank;
	logic is_read;
	logic [19:0] cyc_addr;
	logic [15:0] cyc_data;
	logic cyc_write;
	logic [`FCI_PHASE_W-1:0] pulse_len;

	// ==========================================================
	// sequence table: address, data and direction of each step
	always_comb
	begin
		cyc_write = 1'b1;
		cyc_addr = `FCI_UNLOCK1_ADDR;
		cyc_data = `FCI_UNLOCK1_DATA; // R09
		case (step)
			3'd0:
			begin
				cyc_addr = `FCI_UNLOCK1_ADDR;
				cyc_data = `FCI_UNLOCK1_DATA; // R09
			end
			3'd1, 3'd4:
			begin
				cyc_addr = `FCI_UNLOCK2_ADDR;
				cyc_data = `FCI_UNLOCK2_DATA; // R09
			end
			3'd2:
			begin
				cyc_addr = `FCI_UNLOCK1_ADDR;
				case (op)
					FCI_OP_RESET: cyc_data = `FCI_CODE_RESET; // R04
					FCI_OP_ID: cyc_data = `FCI_CODE_ID; // R11
					FCI_OP_CLEAR: cyc_data = `FCI_CODE_CLEAR_STATUS; // R11
					FCI_OP_STATUS: cyc_data = `FCI_CODE_STATUS; // R13
					FCI_OP_PROGRAM: cyc_data = `FCI_CODE_PROGRAM; // R14
					FCI_OP_SUSPEND: cyc_data = `FCI_CODE_SUSPEND; // R07
					default: cyc_data = `FCI_CODE_ERASE_SETUP; // R14
				endcase
			end
			3'd3:
			begin
				// fourth cycle: read, program write or second unlock
				cyc_addr = addr;
				cyc_data = wdata; // R16 R17
				cyc_write = 1'b0;
				case (op)
					FCI_OP_PROGRAM: cyc_write = 1'b1;
					FCI_OP_CHIP_ERASE, FCI_OP_SECTOR_ERASE:
					begin
						cyc_write = 1'b1;
						cyc_addr = `FCI_UNLOCK1_ADDR;
						cyc_data = `FCI_UNLOCK1_DATA;
					end
					default: cyc_write = 1'b0; // R12 R13 R19
				endcase
			end
			3'd5:
			begin
				if (op == FCI_OP_SECTOR_ERASE)
				begin
					cyc_addr = addr; // R15
					cyc_data = `FCI_CODE_SECTOR_ERASE; // R15
				end
				else
				begin
					cyc_addr = `FCI_UNLOCK1_ADDR;
					cyc_data = `FCI_CODE_CHIP_ERASE; // R14
				end
			end
			default:
			begin
				cyc_write = 1'b0;
				cyc_addr = addr; // R02
			end
		endcase
		pulse_len = cyc_write ? `FCI_PHASE_W'(PULSE_CYC) : `FCI_PHASE_W'(READ_CYC);
	end

	// ==========================================================
	// request capture and step bookkeeping
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			op <= FCI_OP_READ;
			addr <= 20'h00000;
			wdata <= 16'h0000;
			bank <= 1'b0;
			step <= 3'd0;
			last_step <= 3'd0;
		end
		else if (state == FCI_IDLE && i_req)
		begin
			op <= i_op;
			addr <= i_addr;
			wdata <= i_wdata;
			bank <= i_bank_half_select; // R03
			step <= (i_op == FCI_OP_READ) ? 3'd6 : 3'd0; // R21 R22
			case (i_op)
				FCI_OP_READ: last_step <= 3'd6;
				FCI_OP_CLEAR, FCI_OP_SUSPEND: last_step <= 3'd2;
				FCI_OP_CHIP_ERASE, FCI_OP_SECTOR_ERASE: last_step <= 3'd5;
				default: last_step <= 3'd3; // R20
			endcase
		end
		else if (state == FCI_NEXT)
			step <= step + 3'd1;
	end

	// ==========================================================
	// bus cycle sequencer
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			state <= FCI_IDLE;
			count <= '0;
		end
		else
		begin
			case (state)
				FCI_IDLE:
				begin
					count <= `FCI_PHASE_W'(SETUP_CYC);
					if (i_req)
						state <= FCI_SETUP;
				end
				FCI_SETUP:
				begin
					if (count <= `FCI_PHASE_W'(1))
					begin
						state <= FCI_PULSE;
						count <= pulse_len;
					end
					else
						count <= count - `FCI_PHASE_W'(1);
				end
				FCI_PULSE:
				begin
					if (count <= `FCI_PHASE_W'(1))
					begin
						state <= FCI_HOLD;
						count <= `FCI_PHASE_W'(HOLD_CYC);
					end
					else
						count <= count - `FCI_PHASE_W'(1);
				end
				FCI_HOLD:
				begin
					if (count <= `FCI_PHASE_W'(1))
						state <= (step == last_step) ? FCI_DONE : FCI_NEXT;
					else
						count <= count - `FCI_PHASE_W'(1);
				end
				FCI_NEXT:
				begin
					state <= FCI_SETUP;
					count <= `FCI_PHASE_W'(SETUP_CYC);
				end
				FCI_DONE:
					state <= FCI_IDLE;
				default:
					state <= FCI_IDLE;
			endcase
		end
	end

	// ==========================================================
	// pin drive: strobe only inside the pulse phase, address held around it
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_addr <= 20'h00000;
			o_bank_half_select <= 1'b0;
			o_chip_select_n <= 1'b1;
			o_output_gate_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_data <= 16'h0000;
			o_data_oe <= 1'b0;
			is_read <= 1'b0;
		end
		else
		begin
			is_read <= ~cyc_write;
			o_addr <= cyc_addr; // R10
			o_bank_half_select <= bank; // R03
			o_chip_select_n <= ~(state == FCI_SETUP || state == FCI_PULSE || state == FCI_HOLD); // R26
			o_output_gate_n <= ~(state == FCI_PULSE && !cyc_write); // R02 R23
			o_write_strobe_n <= ~(state == FCI_PULSE && cyc_write); // R01 R16 R17
			o_data <= cyc_data;
			o_data_oe <= cyc_write && (state == FCI_SETUP || state == FCI_PULSE || state == FCI_HOLD); // R01
		end
	end

	// ==========================================================
	// handshake outputs and read capture
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
			o_engine_ready <= 1'b0;
			o_identification_high_voltage <= 1'b0;
		end
		else
		begin
			o_busy <= (state != FCI_IDLE) || i_req;
			o_done <= (state == FCI_HOLD) && (count <= `FCI_PHASE_W'(1)) && (step == last_step);
			o_identification_high_voltage <= i_id_high_voltage; // R18
			// sample read data at end of the output gate pulse
			if (state == FCI_PULSE && count <= `FCI_PHASE_W'(1) && is_read)
			begin
				o_rdata <= i_data;
				o_engine_ready <= i_data[7] & i_data[15]; // R24 R08
			end
		end
	end
endmodule // fci_host

/* fci_host_chk.sv */
// pin protocol checks for the flash host controller
`timescale 1ns/100ps
module fci_host_chk
(
	// watched ports
	input wire logic i_ref_clk, i_sys_rst, i_id_high_voltage,
	input wire logic [19:0] o_addr,
	input wire logic [15:0] o_data,
	input wire logic o_bank_half_select, o_chip_select_n, o_output_gate_n, o_write_strobe_n,
	input wire logic o_identification_high_voltage, o_data_oe
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// strobe phases
	sequence s_wr; (!o_write_strobe_n && !o_chip_select_n && o_output_gate_n)[*8]; endsequence
	sequence s_rd; (!o_output_gate_n && !o_chip_select_n && o_write_strobe_n)[*8]; endsequence
	property p_wr; !o_write_strobe_n |-> o_data_oe && o_output_gate_n && !o_chip_select_n; endproperty
	a_wr: assert property (p_wr) else $error("bad write");
	property p_pulse; $fell(o_write_strobe_n) |-> s_wr; endproperty
	a_pulse: assert property (p_pulse) else $error("short write");
	property p_rd; $fell(o_output_gate_n) |-> s_rd; endproperty
	a_rd: assert property (p_rd) else $error("bad read");
	property p_oe; !o_output_gate_n |-> !o_data_oe; endproperty
	a_oe: assert property (p_oe) else $error("contention");
	property p_bank; !o_chip_select_n && $past(!o_chip_select_n) |-> $stable(o_bank_half_select); endproperty
	a_bank: assert property (p_bank) else $error("bank moved");
	property p_addr; !o_write_strobe_n && $past(!o_write_strobe_n) |-> $stable(o_addr); endproperty
	a_addr: assert property (p_addr) else $error("addr moved");
	property p_data; $rose(o_write_strobe_n) |-> $stable(o_data) && !o_chip_select_n; endproperty
	a_data: assert property (p_data) else $error("data moved");
	property p_hv; o_identification_high_voltage == $past(i_id_high_voltage); endproperty
	a_hv: assert property (p_hv) else $error("hv lag");
endmodule // fci_host_chk
bind fci_host fci_host_chk i_chk (.*);

/* fci_flash.sv */
// behavioural flash device on the host pins
`timescale 1ns/100ps
module fci_flash
#(parameter logic [15:0] MAKER = 16'h0011, PART = 16'h0022) // arbitrary codes
(
	// device pins
	input wire logic [19:0] i_addr,
	input wire logic i_bank, i_ce_n, i_oe_n, i_we_n, i_hv,
	input wire logic [15:0] i_d,
	output logic [15:0] o_q
);
	logic [15:0] mem [32]; // index holds address bit 16, bank, address bits 2 to 0
	logic [19:0] la;
	logic lb;
	logic [2:0] st = 0;
	logic [1:0] md = 0; // array mode at power-up
	logic [15:0] v = 0;
	realtime rdy = 0;
	wire k5 = la[14:0] == 15'h5555;
	wire k2 = la[14:0] == 15'h2aaa;
	wire [7:0] c = i_d[7:0];
	initial foreach (mem[k]) mem[k] = 16'hffff;
	// address latch on strobe fall
	always @(negedge i_we_n) if (!i_ce_n) {lb, la} = {i_bank, i_addr};
	// command latch on strobe rise
	always @(posedge i_we_n) if (!i_ce_n)
		case (st)
		0: st = k5 && c == 8'haa ? 1 : 0;
		1: st = k2 && c == 8'h55 ? 2 : 0;
		2:
		begin
			st = 0;
			if (!k5) ;
			else if (c == 8'h70) md = 2;
			else if ($realtime < rdy) ;
			else if (c == 8'hf0) md = 0;
			else if (c == 8'h90) md = 1;
			else if (c == 8'ha0) st = 3;
			else if (c == 8'h80) st = 4;
		end
		3:
		begin
			mem[{la[16], lb, la[2:0]}] = i_d;
			st = 0;
			md = 2;
			rdy = $realtime + 5000;
		end
		4: st = k5 && c == 8'haa ? 5 : 0;
		5: st = k2 && c == 8'h55 ? 6 : 0;
		default:
		begin
			st = 0;
			if (k5 && c == 8'h10 || c == 8'h30)
			begin
				// sector erase clears only words whose address bit 16 matches the sector address
				foreach (mem[k]) if (c == 8'h10 || k[4] == la[16]) mem[k] = 16'hffff;
				md = 2;
				rdy = $realtime + 5000;
			end
		end
		endcase
	// drive when selected with gate low, else show inverse
	always @*
		if (!i_ce_n && !i_oe_n && i_we_n)
		begin
			if (i_hv || md == 1) v = i_addr[0] ? PART : MAKER;
			else if (md == 2) v = $realtime < rdy ? 16'h0000 : 16'h8080;
			else v = mem[{i_addr[16], i_bank, i_addr[2:0]}];
			o_q = v;
		end
		else o_q = ~v;
endmodule // fci_flash

/* fci_host_tb.sv */
// testbench for the flash host controller
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t got %h", $time, a); end end
module fci_host_tb;
	import fci_pkg::*;
	logic clk = 0, rst = 1, req = 0, bank = 0, hv = 0;
	fci_op_type op = FCI_OP_READ;
	logic [19:0] ad = 0, pa;
	logic [15:0] wd = 0, rd, q, od;
	logic bsy, dn, rdy, pb, cs_n, oe_n, we_n, phv, doe;
	int fails = 0, checked = 0;
	wire [15:0] dl = doe ? od : q;
	fci_host i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_op(op), .i_addr(ad), .i_wdata(wd),
		.i_bank_half_select(bank), .i_id_high_voltage(hv), .o_busy(bsy), .o_done(dn), .o_rdata(rd),
		.o_engine_ready(rdy), .o_addr(pa), .o_bank_half_select(pb), .o_chip_select_n(cs_n),
		.o_output_gate_n(oe_n), .o_write_strobe_n(we_n), .o_identification_high_voltage(phv),
		.o_data(od), .o_data_oe(doe), .i_data(dl));
	fci_flash i_mem (.i_addr(pa), .i_bank(pb), .i_ce_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_hv(phv), .i_d(dl), .o_q(q));
	initial forever #2.5 clk = ~clk;
	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// one request, bounded wait for done, one idle cycle
	task automatic go(input fci_op_type o, input logic [19:0] a, input logic [15:0] d, input logic b);
		int n;
		op <= o;
		ad <= a;
		wd <= d;
		bank <= b;
		req <= 1'b1;
		@(posedge clk) req <= 1'b0;
		for (n = 0; n < 1000 && dn !== 1'b1; n++) @(negedge clk);
		if (n == 1000)
		begin
			fails++;
			complete_run();
		end
		`CHK(bsy, 1'b1)
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK(bsy, 1'b0)
		@(posedge clk);
	endtask
	// always read status at least once, earlier array reads may leave the ready flag set
	task automatic wait_ready;
		for (int n = 0; n < 20; n++)
		begin
			go(FCI_OP_STATUS, 0, 0, 0);
			if (rdy === 1'b1) break;
		end
		`CHK(rd, 16'h8080)
	endtask
	task automatic t_id;
		go(FCI_OP_READ, 20'h3, 0, 0); `CHK(rd, 16'hffff)
		go(FCI_OP_ID, 20'h0, 0, 0); `CHK(rd, 16'h0011)
		go(FCI_OP_READ, 20'h1, 0, 0); `CHK(rd, 16'h0022)
		go(FCI_OP_RESET, 20'h1, 0, 0); `CHK(rd, 16'hffff)
		hv <= 1'b1;
		go(FCI_OP_READ, 20'h1, 0, 0); `CHK(rd, 16'h0022)
		hv <= 1'b0;
		$display("t_id done");
	endtask
	task automatic t_prog;
		go(FCI_OP_PROGRAM, 20'h2, 16'h1234, 0);
		go(FCI_OP_RESET, 20'h2, 0, 0); `CHK(rd, 16'h0000)
		wait_ready();
		go(FCI_OP_READ, 20'h2, 0, 0); `CHK(rd, 16'h8080)
		go(FCI_OP_RESET, 20'h2, 0, 0); `CHK(rd, 16'h1234)
		go(FCI_OP_READ, 20'h2, 0, 1); `CHK(rd, 16'hffff)
		$display("t_prog done");
	endtask
	task automatic t_erase;
		go(FCI_OP_SECTOR_ERASE, 20'h10000, 0, 0);
		go(FCI_OP_SUSPEND, 0, 0, 0);
		go(FCI_OP_CLEAR, 0, 0, 0);
		wait_ready();
		go(FCI_OP_RESET, 20'h2, 0, 0); `CHK(rd, 16'h1234)
		go(FCI_OP_CHIP_ERASE, 0, 0, 0);
		wait_ready();
		go(FCI_OP_RESET, 20'h2, 0, 0); `CHK(rd, 16'hffff)
		$display("t_erase done");
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_id();
		t_prog();
		t_erase();
		complete_run();
	end
endmodule // fci_host_tb
